// *** rtl/pomc_top.sv ***
// Contract
// R1 - Ports A,C,D,E have mode registers, reset zero
// R2 - Pins without mode bits use direction only
// R3 - Input: mode 1 adds interrupt on A,C,D
// R4 - Output: mode 0 open drain, 1 push-pull
// R5 - Registers decoded as consecutive bytes, 05h unused
// R6 - Every port register resets to zero
// R7 - Bits 7:6 set port A trigger sense
// R8 - Bits 4:3 set port D trigger sense
// R9 - Sense fields writable only at mask level 3
// R10 - Bit 5 routes core clock to pin
// R11 - Divider off: default 3 or 6 MHz
// R12 - Stand-alone divider select gives four rates
// R13 - USB mode divider select gives four rates
// R14 - No buffer access at 6 MHz stand-alone
// R15 - Software avoids buffer access at slow USB clocks
// R16 - Divider leaves coprocessor clock untouched
// R17 - Direction bit 0 input, 1 output
// R18 - Pin inputs synchronised, one request per event
// R19 - Divider changes only at period boundary
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "pomc_defs.svh"
module pomc_top #(
  parameter int NPORT = 6,
  parameter int PW    = 8
) (
  input  wire logic              clk_sys_in,
  input  wire logic              resetn_in,
  input  wire logic [4:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output var  logic [7:0]        reg_rdata_out,
  input  wire logic              irq_mask_high_in,
  input  wire logic              irq_mask_low_in,
  input  wire logic              usb_mode_in,
  input  wire logic              xfer_clk_tick_in,
  input  wire logic [NPORT*PW-1:0] pin_in,
  output var  logic [NPORT*PW-1:0] pin_out,
  output var  logic [NPORT*PW-1:0] pin_oe_n_out,
  output var  logic              port_a_ext_irq_out,
  output var  logic              port_c_ext_irq_out,
  output var  logic              port_d_ext_irq_out,
  output var  logic              irq_out,
  output var  logic              core_clk_out,
  output var  logic              core_tick_out,
  output var  logic              xfer_clk_tick_out,
  output var  logic              usb_buf_access_ok_out
);
  if (NPORT != 6 || PW != 8) begin : g_bad_size
    $error("pomc_top: only six eight-bit ports are supported");
  end

  localparam int NB = NPORT * PW;
  localparam logic [4:0] OFF_VAL [6] = '{`POMC_OFF_A_VAL, `POMC_OFF_B_VAL,
    `POMC_OFF_C_VAL, `POMC_OFF_D_VAL, `POMC_OFF_E_VAL, `POMC_OFF_F_VAL};
  localparam logic [4:0] OFF_DIR [6] = '{`POMC_OFF_A_DIR, `POMC_OFF_B_DIR,
    `POMC_OFF_C_DIR, `POMC_OFF_D_DIR, `POMC_OFF_E_DIR, `POMC_OFF_F_DIR};
  localparam logic [4:0] OFF_MODE [6] = '{`POMC_OFF_A_MODE, `POMC_OFF_UNUSED,
    `POMC_OFF_C_MODE, `POMC_OFF_D_MODE, `POMC_OFF_E_MODE, `POMC_OFF_UNUSED};
  localparam logic [5:0] HAS_MODE = 6'h1d;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [NB-1:0] val_q;
  logic [NB-1:0] dir_q;
  logic [NB-1:0] mode_q;
  logic [7:0]    misc_q;
  logic [2:0]    irq_st_q;
  logic [2:0]    irq_en_q;
  logic [2:0]    irq_req_q;
  logic [NB-1:0] pin_prev_q;
  logic [NB-1:0] pin_sync;
  logic          core_clk;
  logic          core_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [5:0] hit_val;
  logic [5:0] hit_dir;
  logic [5:0] hit_mode;
  logic [NB-1:0] has_mode_bits;

  genvar gp;
  generate
    for (gp = 0; gp < 6; gp++) begin : g_dec
      assign hit_val[gp]  = (reg_addr_in == OFF_VAL[gp]); // R5
      assign hit_dir[gp]  = (reg_addr_in == OFF_DIR[gp]); // R5
      assign hit_mode[gp] = HAS_MODE[gp]
                            && (reg_addr_in == OFF_MODE[gp]); // R5
      assign has_mode_bits[gp*PW +: PW] = {PW{HAS_MODE[gp]}};
    end
  endgenerate

  wire hit_misc   = (reg_addr_in == `POMC_OFF_MISC);
  wire hit_irq_st = (reg_addr_in == `POMC_OFF_IRQ_ST);
  wire hit_irq_cl = (reg_addr_in == `POMC_OFF_IRQ_CLR);
  wire hit_irq_en = (reg_addr_in == `POMC_OFF_IRQ_EN);
  wire level3     = irq_mask_high_in & irq_mask_low_in; // R9
  wire misc_wr    = reg_wr_in & hit_misc;

  ////////////////////////////////////////////////////////////////////////////
  // Misc control: sense fields kept unless at level 3

  wire [1:0] a_sense_wr = level3 ?
    reg_wdata_in[`POMC_MISC_A_SENSE_HI:`POMC_MISC_A_SENSE_LO] :
    misc_q[`POMC_MISC_A_SENSE_HI:`POMC_MISC_A_SENSE_LO]; // R9
  wire [1:0] d_sense_wr = level3 ?
    reg_wdata_in[`POMC_MISC_D_SENSE_HI:`POMC_MISC_D_SENSE_LO] :
    misc_q[`POMC_MISC_D_SENSE_HI:`POMC_MISC_D_SENSE_LO]; // R9
  wire [7:0] misc_d = {a_sense_wr, reg_wdata_in[`POMC_MISC_CLK_PIN],
    d_sense_wr, reg_wdata_in[`POMC_MISC_DIV_HI:`POMC_MISC_DIV_EN]};

  pomc_pkg::pomc_sense_t a_sense;
  pomc_pkg::pomc_sense_t d_sense;
  assign a_sense = pomc_pkg::pomc_sense_t'(
    misc_q[`POMC_MISC_A_SENSE_HI:`POMC_MISC_A_SENSE_LO]); // R7
  assign d_sense = pomc_pkg::pomc_sense_t'(
    misc_q[`POMC_MISC_D_SENSE_HI:`POMC_MISC_D_SENSE_LO]); // R8

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      val_q  <= {NPORT{`POMC_RST_REG}}; // R6
      dir_q  <= {NPORT{`POMC_RST_REG}}; // R6
      mode_q <= {NPORT{`POMC_RST_REG}}; // R1
      misc_q <= `POMC_RST_REG;
    end else begin
      for (int p = 0; p < 6; p++) begin
        if (reg_wr_in && hit_val[p]) begin
          val_q[p*PW +: PW] <= reg_wdata_in;
        end
        if (reg_wr_in && hit_dir[p]) begin
          dir_q[p*PW +: PW] <= reg_wdata_in; // R17
        end
        if (reg_wr_in && hit_mode[p]) begin
          mode_q[p*PW +: PW] <= reg_wdata_in; // R1
        end
      end
      if (misc_wr) begin
        misc_q <= misc_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data stand one cycle after the strobe only

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int p = 0; p < 6; p++) begin
      if (hit_val[p]) begin
        rd_mux = rd_mux | pin_sync[p*PW +: PW];
      end
      if (hit_dir[p]) begin
        rd_mux = rd_mux | dir_q[p*PW +: PW];
      end
      if (hit_mode[p]) begin
        rd_mux = rd_mux | mode_q[p*PW +: PW];
      end
    end
    if (hit_misc) begin
      rd_mux = misc_q;
    end
    if (hit_irq_st) begin
      rd_mux = {5'h00, irq_st_q};
    end
    if (hit_irq_en) begin
      rd_mux = {5'h00, irq_en_q};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive

  wire [NB-1:0] push_pull = dir_q & (mode_q | ~has_mode_bits); // R2 R4
  wire [NB-1:0] open_drn  = dir_q & ~mode_q & has_mode_bits; // R4
  wire          clk_pin   = misc_q[`POMC_MISC_CLK_PIN]; // R10

  logic [NB-1:0] out_d;
  logic [NB-1:0] oe_n_d;
  always_comb begin
    out_d  = val_q & push_pull; // R4
    oe_n_d = ~(push_pull | (open_drn & ~val_q)); // R3 R4 R17
    if (clk_pin) begin // R10
      out_d[`POMC_CLK_PIN_IDX]  = core_clk;
      oe_n_d[`POMC_CLK_PIN_IDX] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_out      <= '0;
      pin_oe_n_out <= '1;
    end else begin
      pin_out      <= out_d;
      pin_oe_n_out <= oe_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and interrupt detection

  pomc_sync #(.W(NB)) u_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .d_in       (pin_in),
    .q_out      (pin_sync)
  );

  wire [NB-1:0] irq_pin = ~dir_q & mode_q; // R3
  wire [NB-1:0] rise    = pin_sync & ~pin_prev_q & irq_pin; // R18
  wire [NB-1:0] fall    = ~pin_sync & pin_prev_q & irq_pin; // R18
  wire [NB-1:0] low     = ~pin_sync & irq_pin;

  function automatic logic sense_hit(input pomc_pkg::pomc_sense_t s,
                                     input logic [7:0] r,
                                     input logic [7:0] f,
                                     input logic [7:0] l);
    logic hit;
    hit = 1'b0;
    case (s)
      pomc_pkg::POMC_SENSE_LOW_FALL: hit = |(f | l);
      pomc_pkg::POMC_SENSE_RISE:     hit = |r;
      pomc_pkg::POMC_SENSE_FALL:     hit = |f;
      default:                       hit = |(r | f);
    endcase
    return hit;
  endfunction : sense_hit

  wire req_a = sense_hit(a_sense, rise[7:0], fall[7:0], low[7:0]); // R7
  wire req_c = sense_hit(pomc_pkg::POMC_SENSE_LOW_FALL, rise[23:16],
                         fall[23:16], low[23:16]);
  wire req_d = sense_hit(d_sense, rise[31:24], fall[31:24],
                         low[31:24]); // R8
  wire [2:0] req_d3 = {req_d, req_c, req_a};
  wire [2:0] clr_mask = (reg_wr_in && hit_irq_cl) ? reg_wdata_in[2:0] : 3'h0;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_prev_q <= '0;
      irq_req_q  <= `POMC_RST_IRQ;
      irq_st_q   <= `POMC_RST_IRQ;
      irq_en_q   <= `POMC_RST_IRQ;
      irq_out    <= 1'b0;
    end else begin
      pin_prev_q <= pin_sync;
      irq_req_q  <= req_d3; // R18
      irq_st_q   <= (irq_st_q & ~clr_mask) | irq_req_q;
      irq_en_q   <= (reg_wr_in && hit_irq_en) ? reg_wdata_in[2:0] : irq_en_q;
      irq_out    <= |(((irq_st_q & ~clr_mask) | irq_req_q) & irq_en_q);
    end
  end

  assign port_a_ext_irq_out = irq_req_q[`POMC_IRQ_A];
  assign port_c_ext_irq_out = irq_req_q[`POMC_IRQ_C];
  assign port_d_ext_irq_out = irq_req_q[`POMC_IRQ_D];

  ////////////////////////////////////////////////////////////////////////////
  // Core clock divider and buffer access gate

  pomc_clkdiv #(.CW(8)) u_div (
    .clk_sys_in     (clk_sys_in),
    .resetn_in      (resetn_in),
    .usb_mode_in    (usb_mode_in),
    .div_en_in      (misc_q[`POMC_MISC_DIV_EN]),
    .div_sel_in     (misc_q[`POMC_MISC_DIV_HI:`POMC_MISC_DIV_LO]),
    .core_clk_out   (core_clk),
    .core_tick_out  (core_tick),
    .ratio_load_out ()
  );

  wire sa_fast = !usb_mode_in && misc_q[`POMC_MISC_DIV_EN]
                 && (misc_q[`POMC_MISC_DIV_HI:`POMC_MISC_DIV_LO] == 2'h0);

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      core_clk_out          <= 1'b0;
      core_tick_out         <= 1'b0;
      xfer_clk_tick_out     <= 1'b0;
      usb_buf_access_ok_out <= 1'b0;
    end else begin
      core_clk_out          <= core_clk;
      core_tick_out         <= core_tick;
      xfer_clk_tick_out     <= xfer_clk_tick_in; // R16
      usb_buf_access_ok_out <= !sa_fast; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_sense_write_lock: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    (misc_wr && !level3) |=> (misc_q[7:6] == $past(misc_q[7:6]))
      && (misc_q[4:3] == $past(misc_q[4:3]))) // R9
    else $error("sense field changed outside level 3");

  chk_regs_reset_zero: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    $past(!resetn_in) |-> (val_q == '0) && (dir_q == '0)
      && (mode_q == '0)) // R6
    else $error("port register not zero after reset");

  chk_push_pull_drive: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    !$past(clk_pin) |-> ((pin_oe_n_out & $past(push_pull)) == '0)
      && (((pin_out ^ $past(val_q)) & $past(push_pull)) == '0)) // R4
    else $error("push-pull pin not driven with its value");

  chk_open_drain_hi: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    !$past(clk_pin) |-> ((~pin_oe_n_out & $past(open_drn)
      & $past(val_q)) == '0)) // R4
    else $error("open drain pin drove high");

  chk_input_floats: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    !$past(clk_pin) |-> ((~pin_oe_n_out & ~$past(dir_q)) == '0)) // R17
    else $error("input pin is being driven");

  chk_clock_on_pin: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    clk_pin ##1 clk_pin |-> !pin_oe_n_out[`POMC_CLK_PIN_IDX]
      && (pin_out[`POMC_CLK_PIN_IDX] == $past(core_clk))) // R10
    else $error("core clock not routed to its pin");

  chk_buf_block: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    sa_fast ##1 sa_fast |-> !usb_buf_access_ok_out) // R14
    else $error("buffer access allowed at fast stand-alone clock");

  chk_rise_one_pulse: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    (a_sense == pomc_pkg::POMC_SENSE_RISE) && $stable(a_sense)
      && port_a_ext_irq_out |=> !port_a_ext_irq_out
      || ($past(pin_sync[7:0]) != $past(pin_sync[7:0], 2))) // R18
    else $error("edge request lasted more than one event");
endmodule : pomc_top
`default_nettype wire

// *** common/pomc_defs.svh ***
`ifndef POMC_DEFS_SVH
`define POMC_DEFS_SVH

// Port register byte offsets
`define POMC_OFF_A_VAL   5'h00
`define POMC_OFF_A_DIR   5'h01
`define POMC_OFF_A_MODE  5'h02
`define POMC_OFF_B_VAL   5'h03
`define POMC_OFF_B_DIR   5'h04
`define POMC_OFF_UNUSED  5'h05
`define POMC_OFF_C_VAL   5'h06
`define POMC_OFF_C_DIR   5'h07
`define POMC_OFF_C_MODE  5'h08
`define POMC_OFF_D_VAL   5'h09
`define POMC_OFF_D_DIR   5'h0a
`define POMC_OFF_D_MODE  5'h0b
`define POMC_OFF_E_VAL   5'h0c
`define POMC_OFF_E_DIR   5'h0d
`define POMC_OFF_E_MODE  5'h0e
`define POMC_OFF_F_VAL   5'h0f
`define POMC_OFF_F_DIR   5'h10
`define POMC_OFF_MISC    5'h11
`define POMC_OFF_IRQ_ST  5'h12
`define POMC_OFF_IRQ_CLR 5'h13
`define POMC_OFF_IRQ_EN  5'h14

// Misc control field positions
`define POMC_MISC_A_SENSE_HI 7
`define POMC_MISC_A_SENSE_LO 6
`define POMC_MISC_CLK_PIN    5
`define POMC_MISC_D_SENSE_HI 4
`define POMC_MISC_D_SENSE_LO 3
`define POMC_MISC_DIV_HI     2
`define POMC_MISC_DIV_LO     1
`define POMC_MISC_DIV_EN     0

// Reset values
`define POMC_RST_REG 8'h00
`define POMC_RST_IRQ 3'h0

// Interrupt status bits
`define POMC_IRQ_A 0
`define POMC_IRQ_C 1
`define POMC_IRQ_D 2

// Core clock alternate pin: port C pin 7 (flat index)
`define POMC_CLK_PIN_IDX 23

// Source cycles per core clock period
`define POMC_DIV_SA_DEF  8'd4
`define POMC_DIV_SA_00   8'd2
`define POMC_DIV_SA_10   8'd8
`define POMC_DIV_SA_01   8'd16
`define POMC_DIV_SA_11   8'd32
`define POMC_DIV_USB_DEF 8'd8
`define POMC_DIV_USB_00  8'd6
`define POMC_DIV_USB_10  8'd24
`define POMC_DIV_USB_01  8'd48
`define POMC_DIV_USB_11  8'd192

`endif

// *** common/pomc_pkg.sv ***
package pomc_pkg;
  typedef enum logic [1:0] {
    POMC_SENSE_LOW_FALL,
    POMC_SENSE_RISE,
    POMC_SENSE_FALL,
    POMC_SENSE_BOTH
  } pomc_sense_t;
endpackage : pomc_pkg

// *** rtl/pomc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pomc_sync #(
  parameter int W = 48
) (
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  if (W < 1) begin : g_bad_width
    $error("pomc_sync: W must be positive");
  end

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      q_out <= '0;
    end else begin
      s1_q  <= d_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      q_out <= (agree & s3_q) | (~agree & q_out); // R18
    end
  end

  chk_sync_agree_hold: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    ((q_out ^ $past(q_out)) & ~$past(agree)) == '0) // R18
    else $error("sync output moved while stages disagree");
endmodule : pomc_sync
`default_nettype wire

// *** rtl/pomc_clkdiv.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pomc_defs.svh"
module pomc_clkdiv #(
  parameter int CW = 8
) (
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic       usb_mode_in,
  input  wire logic       div_en_in,
  input  wire logic [1:0] div_sel_in,
  output var  logic       core_clk_out,
  output var  logic       core_tick_out,
  output var  logic       ratio_load_out
);
  if (CW < 8) begin : g_bad_width
    $error("pomc_clkdiv: CW too small for 192");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] ratio_q;
  logic [CW-1:0] ratio_d;

  always_comb begin
    ratio_d = CW'(`POMC_DIV_SA_DEF);
    if (!div_en_in) begin // R11
      ratio_d = usb_mode_in ? CW'(`POMC_DIV_USB_DEF) : CW'(`POMC_DIV_SA_DEF);
    end else if (usb_mode_in) begin // R13
      case (div_sel_in)
        2'h0: ratio_d = CW'(`POMC_DIV_USB_00);
        2'h2: ratio_d = CW'(`POMC_DIV_USB_10);
        2'h1: ratio_d = CW'(`POMC_DIV_USB_01);
        default: ratio_d = CW'(`POMC_DIV_USB_11);
      endcase
    end else begin // R12
      case (div_sel_in)
        2'h0: ratio_d = CW'(`POMC_DIV_SA_00);
        2'h2: ratio_d = CW'(`POMC_DIV_SA_10);
        2'h1: ratio_d = CW'(`POMC_DIV_SA_01);
        default: ratio_d = CW'(`POMC_DIV_SA_11);
      endcase
    end
  end

  wire last = (cnt_q == ratio_q - CW'(1));

  // New ratio only at a period boundary, so no runt pulse
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cnt_q          <= '0;
      ratio_q        <= CW'(`POMC_DIV_SA_DEF);
      core_clk_out   <= 1'b0;
      core_tick_out  <= 1'b0;
      ratio_load_out <= 1'b0;
    end else begin
      cnt_q          <= last ? '0 : cnt_q + CW'(1);
      ratio_q        <= last ? ratio_d : ratio_q; // R19
      core_clk_out   <= last ? 1'b1 : (cnt_q + CW'(1) < (ratio_q >> 1));
      core_tick_out  <= last;
      ratio_load_out <= last;
    end
  end

  chk_div_ratio_stable: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    !$past(last) |-> $stable(ratio_q)) // R19
    else $error("divider ratio changed mid period");
endmodule : pomc_clkdiv
`default_nettype wire

// *** tb/pomc_board_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module pomc_board_model (
  input  wire logic        clk_sys_in,
  input  wire logic [47:0] pin_out_in,
  input  wire logic [47:0] pin_oe_n_in,
  input  wire logic [47:0] ext_en_in,
  input  wire logic [47:0] ext_val_in,
  output var  logic [47:0] level_out
);
  logic [47:0] last_q;
  // Pad driven low-active enable wins, then the board, else the line wanders
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      if (pin_oe_n_in[i] == 1'b0) begin
        level_out[i] = pin_out_in[i];
      end else if (ext_en_in[i]) begin
        level_out[i] = ext_val_in[i];
      end else begin
        level_out[i] = ~last_q[i];
      end
    end
  end
  initial last_q = '0;
  always @(posedge clk_sys_in) begin
    last_q <= level_out;
  end
endmodule : pomc_board_model
`default_nettype wire

// *** tb/port_option_and_misc_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module port_option_and_misc_control_test;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, rdata, rv;
  logic        mh = 1'b0, ml = 1'b0, usb = 1'b0, xin = 1'b0;
  logic [47:0] lvl, pout, poe, ext_en = '1, ext_val = '0;
  logic        irq_a, irq_c, irq_d, irq, cclk, ctick, xout, bufok;
  int          err_count = 0, total_checks = 0, n;
  logic [4:0]  rw_list [10] = '{5'h01, 5'h02, 5'h04, 5'h07, 5'h08,
                                5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h10};
  logic [7:0]  div_tab [10] = '{8'd4, 8'd2, 8'd16, 8'd8, 8'd32,
                                8'd8, 8'd6, 8'd48, 8'd24, 8'd192};
  always #50 clk = ~clk;
  pomc_top u_dut (
    .clk_sys_in(clk), .resetn_in(rstn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_mask_high_in(mh), .irq_mask_low_in(ml),
    .usb_mode_in(usb), .xfer_clk_tick_in(xin), .pin_in(lvl),
    .pin_out(pout), .pin_oe_n_out(poe), .port_a_ext_irq_out(irq_a),
    .port_c_ext_irq_out(irq_c), .port_d_ext_irq_out(irq_d),
    .irq_out(irq), .core_clk_out(cclk), .core_tick_out(ctick),
    .xfer_clk_tick_out(xout), .usb_buf_access_ok_out(bufok));
  pomc_board_model u_board (
    .clk_sys_in(clk), .pin_out_in(pout), .pin_oe_n_in(poe),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(logic [4:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_cyc(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : wait_cyc
  // Count cycles with the request high on port A (p=0), D (p=1) or C (p=2), over ten cycles
  task automatic cnt_irq(int p, output int c);
    c = 0;
    repeat (10) begin
      @(posedge clk);
      #1 if ((p == 0 ? irq_a : p == 1 ? irq_d : irq_c) === 1'b1) c++;
    end
  endtask : cnt_irq
  task automatic tick_gap(output int c);
    c = 0;
    for (int i = 0; i < 600 && ctick !== 1'b1; i++) wait_cyc(1);
    wait_cyc(1);
    for (c = 1; c < 600 && ctick !== 1'b1; c++) wait_cyc(1);
  endtask : tick_gap
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #5000000;
    err_count++;
    summarize();
  end
  initial begin
    logic [1:0] cd;
    int         pb;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values across the whole map
    for (int a = 0; a <= 20; a++) begin
      rd_reg(a[4:0], rv);
      chk("reset value", rv, 8'h00);
    end
    // Read/write registers, unused hole
    foreach (rw_list[i]) wr_reg(rw_list[i], 8'ha5 ^ {3'h0, rw_list[i]});
    wr_reg(5'h05, 8'hff);
    foreach (rw_list[i]) begin
      rd_reg(rw_list[i], rv);
      chk("rw reg", rv, 8'ha5 ^ {3'h0, rw_list[i]});
    end
    rd_reg(5'h05, rv);
    chk("unused", rv, 8'h00);
    // Output drive kinds
    ext_en <= '0;
    wr_reg(5'h00, 8'h55);
    wr_reg(5'h02, 8'h0f);
    wr_reg(5'h01, 8'hff);
    wr_reg(5'h03, 8'h3c);
    wr_reg(5'h04, 8'hff);
    wait_cyc(2);
    chk("a oe_n", poe[7:0], 8'h50);
    chk("a out", pout[3:0], 4'h5);
    chk("b oe_n", poe[15:8], 8'h00);
    chk("b out", pout[15:8], 8'h3c);
    foreach (rw_list[i]) wr_reg(rw_list[i], 8'h00);
    wait_cyc(2);
    chk("in oe_n", poe, 48'hffff_ffff_ffff);
    // Sense fields guarded by mask level
    ext_en <= '1;
    wr_reg(5'h11, 8'hff);
    rd_reg(5'h11, rv);
    chk("misc lvl0", rv, 8'h27);
    mh <= 1'b1;
    ml <= 1'b1;
    wr_reg(5'h11, 8'hd8);
    rd_reg(5'h11, rv);
    chk("misc lvl3", rv, 8'hd8);
    // Edge and level sensing, ports A and D
    wr_reg(5'h02, 8'h01);
    wr_reg(5'h0b, 8'h01);
    wr_reg(5'h13, 8'h07);
    wr_reg(5'h14, 8'h01);
    for (int p = 0; p < 2; p++) begin
      pb = (p == 0) ? 0 : 24;
      for (int c = 0; c < 4; c++) begin
        cd = c[1:0];
        ext_val[pb] <= 1'b1;
        wait_cyc(8);
        wr_reg(5'h11, p == 0 ? {cd, 6'h00} : {3'h0, cd, 3'h0});
        ext_val[pb] <= 1'b0;
        cnt_irq(p, n);
        if (c == 0) begin
          chk("level", n > 1, 1);
        end else begin
          chk("fall", n, cd[1]);
        end
        ext_val[pb] <= 1'b1;
        cnt_irq(p, n);
        if (c != 0) chk("rise", n, cd[0]);
        ext_val[pb] <= 1'b0;
        wait_cyc(8);
      end
    end
    rd_reg(5'h12, rv);
    chk("status", rv, 8'h05);
    chk("irq on", irq, 1'b1);
    wr_reg(5'h14, 8'h00);
    wait_cyc(2);
    chk("irq masked", irq, 1'b0);
    wr_reg(5'h02, 8'h00);
    wr_reg(5'h12, 8'hff);
    wr_reg(5'h13, 8'h05);
    rd_reg(5'h12, rv);
    chk("cleared", rv, 8'h00);
    ext_val[0] <= 1'b1;
    cnt_irq(0, n);
    chk("no irq mode0", n, 0);
    wr_reg(5'h08, 8'h01);
    cnt_irq(2, n);
    chk("c level", n > 1, 1);
    wr_reg(5'h08, 8'h00);
    // Divider ratios, clock pin, buffer access, coprocessor tick
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 5; s++) begin
        usb <= m[0];
        wr_reg(5'h11, s == 0 ? 8'h20 : {5'h04, 2'(s - 1), 1'b1});
        wait_cyc(1);
        tick_gap(n);
        tick_gap(n);
        tick_gap(n);
        chk("period", n, div_tab[m * 5 + s]);
        chk("buf ok", bufok, !(m == 0 && s == 1));
        chk("clk pin oe", poe[23], 1'b0);
        chk("clk pin", pout[23], cclk);
      end
    end
    wr_reg(5'h11, 8'h00);
    wait_cyc(2);
    chk("clk pin off", poe[23], 1'b1);
    xin <= 1'b1;
    wait_cyc(1);
    xin <= 1'b0;
    chk("xfer tick", xout, 1'b1);
    wait_cyc(1);
    chk("xfer tick end", xout, 1'b0);
    summarize();
  end
endmodule : port_option_and_misc_control_test
`default_nettype wire
